// [core/error_classifier.sv]
`timescale 1ns/100ps
`default_nettype none
module error_classifier (
	input  wire logic                          mclk,
	input  wire logic                          rst,
	input  wire error_queue_pkg::cmd_facts_type facts,
	output var  error_queue_pkg::err_event_type err,
	output var  logic                          trigger_ignore
);
	import error_queue_pkg::*;

	// One code per command; first detected fault in this order wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			err            <= '0;
			trigger_ignore <= 1'b0;
		end else begin
			err.valid      <= 1'b0;
			err.code       <= code_no_error;
			trigger_ignore <= 1'b0;
			if (facts.check) begin
				err.valid <= 1'b1;
				if (facts.params_given < facts.params_needed)
					err.code <= code_missing_param; // RULE8
				else if (facts.exponent_mag > 7'(max_exponent))
					err.code <= code_num_overflow; // RULE9
				else if (facts.value_negative && !facts.negative_allowed)
					err.code <= code_num_negative; // RULE10
				else if (facts.value_fractional && facts.integer_only)
					err.code <= code_num_real; // RULE11
				else if (facts.header_suffix > 4'(max_suffix))
					err.code <= code_bad_suffix; // RULE12
				else if (facts.quote_unmatched)
					err.code <= code_bad_string; // RULE13
				else if (facts.has_string && facts.string_len > 8'(max_string_len))
					err.code <= code_string_size; // RULE14
				else if (facts.bracket_unmatched)
					err.code <= code_brackets; // RULE15
				else if (facts.entry_index >= facts.entry_count)
					err.code <= code_no_entry; // RULE16
				else if (facts.trigger_cmd && !facts.trigger_armed) begin
					err.code       <= code_trig_ignored; // RULE17
					trigger_ignore <= 1'b1; // RULE17
				end else if (facts.init_cmd && facts.meas_running)
					err.code <= code_init_ignored; // RULE18
				else if (facts.read_query && facts.trig_src_bus)
					err.code <= code_trig_deadlock; // RULE19
				else if (facts.db_modifier && !facts.func_has_db)
					err.code <= code_bad_function; // RULE20
				else
					err.valid <= 1'b0;
			end
		end
	end
endmodule : error_classifier
`default_nettype wire

// [core/error_queue_fifo.sv]
// Contract
// RULE1: Queue errors, read back oldest first.
// RULE2: At most sixteen unread entries held.
// RULE3: Full queue: newest entry becomes -350.
// RULE4: After overflow, drop errors until read.
// RULE5: Power-up and clear-status empty the queue.
// RULE6: Reset command leaves queue untouched.
// RULE7: Empty read returns +0, stays empty.
// RULE8: Too few parameters queues -115.
// RULE9: Exponent beyond 43 queues -124.
// RULE10: Disallowed negative value queues -125.
// RULE11: Fraction where integer required queues -126.
// RULE12: Header suffix above allowed queues -137.
// RULE13: Unmatched quote in string queues -150.
// RULE14: String over twelve characters queues -154.
// RULE15: Unmatched bracket queues -157.
// RULE16: Index past last entry queues -193.
// RULE17: Unarmed trigger ignored, queues -211.
// RULE18: Initiate while measuring queues -213.
// RULE19: READ query with bus trigger queues -214.
// RULE20: Decibels on unsupported function queues -227.
// RULE21: Any error sets poll bit six, loads message.
// RULE22: Codes stored signed, wide enough for all.
`timescale 1ns/100ps
`default_nettype none
module error_queue_fifo (
	input  wire logic                           mclk,
	input  wire logic                           rst,
	input  wire error_queue_pkg::cmd_facts_type  facts,
	input  wire logic                           clear_status,
	input  wire logic                           reset_cmd,
	input  wire logic                           device_cmd,
	input  wire logic                           outbuf_read,
	input  wire logic                           queue_read,
	output var  error_queue_pkg::code_type      read_code,
	output var  logic                           read_valid,
	output var  logic [error_queue_pkg::count_width-1:0] queued,
	output var  logic                           overflow_lock,
	output var  logic                           any_error,
	output var  logic                           msg_load,
	output var  error_queue_pkg::code_type      msg_code,
	output var  logic                           trigger_ignore
);
	import error_queue_pkg::*;

	err_event_type             err;
	logic                      trig_ign;
	code_type                  head;
	logic [count_width-1:0]    count;
	logic                      locked;

	error_classifier u_class (
		.mclk           (mclk),
		.rst            (rst),
		.facts          (facts),
		.err            (err),
		.trigger_ignore (trig_ign)
	);

	// The reset command is deliberately not wired to the store
	error_store #(
		.depth (queue_depth),
		.aw    (index_width),
		.cw    (count_width)
	) u_store (
		.mclk   (mclk),
		.rst    (rst),
		.clear  (clear_status), // RULE5 RULE6
		.push   (err),
		.pop    (queue_read),
		.head   (head),
		.count  (count),
		.locked (locked)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			read_code  <= code_no_error;
			read_valid <= 1'b0;
		end else begin
			read_valid <= queue_read;
			if (queue_read)
				read_code <= head; // RULE1 RULE7
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			queued        <= '0;
			overflow_lock <= 1'b0;
		end else begin
			queued        <= count;
			overflow_lock <= locked;
		end
	end

	// Set wins over a clear arriving in the same cycle
	always_ff @(posedge mclk) begin
		if (rst)
			any_error <= 1'b0;
		else if (err.valid)
			any_error <= 1'b1; // RULE21
		else if (device_cmd || outbuf_read || clear_status)
			any_error <= 1'b0;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			msg_load       <= 1'b0;
			msg_code       <= code_no_error;
			trigger_ignore <= 1'b0;
		end else begin
			msg_load       <= err.valid; // RULE21
			trigger_ignore <= trig_ign; // RULE17
			if (err.valid)
				msg_code <= err.code;
		end
	end
endmodule : error_queue_fifo
`default_nettype wire

// [core/error_queue_pkg.sv]
package error_queue_pkg;
	localparam int unsigned code_width     = 12;
	localparam int unsigned queue_depth    = 16;
	localparam int unsigned count_width    = 5;
	localparam int unsigned index_width    = 4;
	localparam int unsigned max_string_len = 12;
	localparam int unsigned max_exponent   = 43;
	localparam int unsigned max_suffix     = 3;
	localparam int unsigned any_error_bit  = 6;
	localparam int unsigned poll_width     = 8;

	typedef logic signed [code_width-1:0] code_type;

	localparam code_type code_no_error      = 12'sh000;
	localparam code_type code_missing_param = -12'sd115;
	localparam code_type code_num_overflow  = -12'sd124;
	localparam code_type code_num_negative  = -12'sd125;
	localparam code_type code_num_real      = -12'sd126;
	localparam code_type code_bad_suffix    = -12'sd137;
	localparam code_type code_bad_string    = -12'sd150;
	localparam code_type code_string_size   = -12'sd154;
	localparam code_type code_brackets      = -12'sd157;
	localparam code_type code_no_entry      = -12'sd193;
	localparam code_type code_trig_ignored  = -12'sd211;
	localparam code_type code_init_ignored  = -12'sd213;
	localparam code_type code_trig_deadlock = -12'sd214;
	localparam code_type code_bad_function  = -12'sd227;
	localparam code_type code_too_many      = -12'sd350;

	// Facts the command parser reports about the command just parsed
	typedef struct packed {
		logic       check;
		logic [3:0] params_given;
		logic [3:0] params_needed;
		logic [6:0] exponent_mag;
		logic       value_negative;
		logic       negative_allowed;
		logic       value_fractional;
		logic       integer_only;
		logic [3:0] header_suffix;
		logic       quote_unmatched;
		logic [7:0] string_len;
		logic       has_string;
		logic       bracket_unmatched;
		logic [7:0] entry_index;
		logic [7:0] entry_count;
		logic       trigger_cmd;
		logic       trigger_armed;
		logic       init_cmd;
		logic       meas_running;
		logic       read_query;
		logic       trig_src_bus;
		logic       db_modifier;
		logic       func_has_db;
	} cmd_facts_type;

	typedef struct packed {
		logic     valid;
		code_type code;
	} err_event_type;
endpackage : error_queue_pkg

// [core/error_store.sv]
`timescale 1ns/100ps
`default_nettype none
module error_store #(
	parameter int unsigned depth = 16,
	parameter int unsigned aw    = 4,
	parameter int unsigned cw    = 5
) (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic                     clear,
	input  wire error_queue_pkg::err_event_type push,
	input  wire logic                     pop,
	output var  error_queue_pkg::code_type head,
	output var  logic [cw-1:0]            count,
	output var  logic                     locked
);
	import error_queue_pkg::*;

	code_type      mem [depth];
	logic [aw-1:0] wr_ptr_r;
	logic [aw-1:0] rd_ptr_r;
	logic          full;
	logic          empty;
	logic          do_pop;
	logic          do_push;
	logic          do_mark;

	function automatic logic [aw-1:0] step(input logic [aw-1:0] p);
		step = (p == aw'(depth - 1)) ? '0 : p + 1'b1;
	endfunction : step

	function automatic logic [aw-1:0] back(input logic [aw-1:0] p);
		back = (p == '0) ? aw'(depth - 1) : p - 1'b1;
	endfunction : back

	assign full    = (count == cw'(depth)); // RULE2
	assign empty   = (count == '0);
	assign do_pop  = pop && !empty; // RULE7
	// A pop in the same cycle frees room, so the new error is kept unless the store is locked
	assign do_push = push.valid && !locked && (!full || do_pop);
	assign do_mark = push.valid && !locked && full && !do_pop; // RULE3
	assign head    = empty ? code_no_error : mem[rd_ptr_r]; // RULE7

	always_ff @(posedge mclk) begin
		if (do_push)
			mem[wr_ptr_r] <= push.code; // RULE1 RULE22
		else if (do_mark)
			mem[back(wr_ptr_r)] <= code_too_many; // RULE3
	end

	always_ff @(posedge mclk) begin
		if (rst || clear) begin // RULE5
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count    <= '0;
		end else begin
			if (do_push)
				wr_ptr_r <= step(wr_ptr_r);
			if (do_pop)
				rd_ptr_r <= step(rd_ptr_r); // RULE1
			if (do_push && !do_pop)
				count <= count + 1'b1;
			else if (do_pop && !do_push)
				count <= count - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || clear)
			locked <= 1'b0;
		else if (do_mark)
			locked <= 1'b1; // RULE4
		else if (do_pop)
			locked <= 1'b0; // RULE4
	end
endmodule : error_store
`default_nettype wire

// [dv/error_queue_fifo_props.sv]
`timescale 1ns/100ps
`default_nettype none
module error_queue_fifo_props
	import error_queue_pkg::*;
(
	input wire logic                   mclk,
	input wire logic                   rst,
	input wire cmd_facts_type          facts,
	input wire logic                   clear_status,
	input wire logic                   queue_read,
	input wire logic                   read_valid,
	input wire logic [count_width-1:0] queued,
	input wire logic                   overflow_lock,
	input wire logic                   msg_load,
	input wire logic                   any_error,
	input wire code_type               msg_code,
	input wire logic                   trigger_ignore
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_read_answered: assert property (queue_read |=> read_valid)
		else $error("read not answered");
	a_depth_limit: assert property (queued <= 5'h10)
		else $error("queue too deep");
	a_lock_when_full: assert property (overflow_lock |-> queued == 5'h10)
		else $error("lock while not full");
	// The lock output lags the store by one cycle, so the last read or clear counts too
	a_lock_holds: assert property (overflow_lock && !queue_read && !$past(queue_read)
		&& !clear_status && !$past(clear_status) |=> overflow_lock)
		else $error("lock lost without read");
	// Pending stores would land after the clear, so they are left out
	a_clear_empties: assert property (clear_status && !msg_load && !facts.check |-> ##2 queued == 5'h00)
		else $error("clear left entries");
	// Classifier register plus output register: the code shows two cycles after the check
	a_missing_code: assert property (facts.check && facts.params_given < facts.params_needed
		|-> ##2 msg_load && msg_code == code_missing_param)
		else $error("missing parameter code");
	a_exp_code: assert property (facts.check && facts.exponent_mag > 7'h2b
		&& facts.params_given >= facts.params_needed |-> ##2 msg_code == code_num_overflow)
		else $error("exponent code");
	a_error_flag: assert property (msg_load |-> any_error)
		else $error("error flag not set with message");
	a_trig_code: assert property (trigger_ignore |-> msg_load && msg_code == code_trig_ignored)
		else $error("trigger code");
endmodule : error_queue_fifo_props
bind error_queue_fifo error_queue_fifo_props i_error_queue_fifo_props (.*);
`default_nettype wire

// [dv/error_queue_fifo_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module error_queue_fifo_tb_top;
	import error_queue_pkg::*;
	logic mclk = 0, rst = 1, go = 0, clear_status = 0, reset_cmd = 0;
	logic device_cmd = 0, outbuf_read = 0, queue_read = 0;
	logic [3:0] kind = 4'h0;
	cmd_facts_type facts;
	code_type read_code, msg_code;
	logic read_valid, overflow_lock, any_error, msg_load, trigger_ignore;
	logic [count_width-1:0] queued;
	int error_cnt = 0, compares = 0, cyc = 0;
	code_type tbl [1:13] = '{code_missing_param, code_num_overflow, code_num_negative,
		code_num_real, code_bad_suffix, code_bad_string, code_string_size, code_brackets,
		code_no_entry, code_trig_ignored, code_init_ignored, code_trig_deadlock, code_bad_function};
	always #10 mclk = ~mclk;
	host_model i_host_model (.mclk(mclk), .kind(kind), .go(go), .facts(facts));
	error_queue_fifo i_error_queue_fifo (.mclk(mclk), .rst(rst), .facts(facts),
		.clear_status(clear_status), .reset_cmd(reset_cmd), .device_cmd(device_cmd),
		.outbuf_read(outbuf_read), .queue_read(queue_read), .read_code(read_code),
		.read_valid(read_valid), .queued(queued), .overflow_lock(overflow_lock),
		.any_error(any_error), .msg_load(msg_load), .msg_code(msg_code),
		.trigger_ignore(trigger_ignore));
	task tick; @(posedge mclk); #1; endtask : tick
	task wait4; repeat (4) tick; endtask : wait4
	task end_of_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	task chk(input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (e !== g) begin
			error_cnt++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task err(input logic [3:0] k);
		kind = k;
		go = 1;
		tick;
		go = 0;
		tick;
	endtask : err
	task pop(input code_type e);
		queue_read = 1;
		tick;
		queue_read = 0;
		chk(1, read_valid);
		chk(e, read_code);
		tick;
	endtask : pop
	task t_codes;
		for (int k = 1; k < 14; k++)
			err(4'(k));
		err(4'he);
		err(4'h0);
		wait4;
		chk(13, queued);
		chk(1, any_error);
		device_cmd = 1;
		tick;
		device_cmd = 0;
		tick;
		chk(0, any_error);
		chk(code_bad_function, msg_code);
		for (int k = 1; k < 14; k++)
			pop(tbl[k]);
		pop(code_no_error);
		wait4;
		chk(0, queued);
	endtask : t_codes
	task t_over;
		for (int i = 0; i < 17; i++)
			err(4'(i % 13 + 1));
		err(4'h2);
		wait4;
		chk(16, queued);
		chk(1, overflow_lock);
		outbuf_read = 1;
		tick;
		outbuf_read = 0;
		chk(0, any_error);
		pop(tbl[1]);
		err(4'h1);
		wait4;
		for (int i = 1; i < 15; i++)
			pop(tbl[i % 13 + 1]);
		pop(code_too_many);
		pop(code_missing_param);
		pop(code_no_error);
	endtask : t_over
	task t_keep;
		err(4'h2);
		err(4'h3);
		wait4;
		reset_cmd = 1;
		tick;
		reset_cmd = 0;
		tick;
		pop(code_num_overflow);
		clear_status = 1;
		tick;
		clear_status = 0;
		wait4;
		chk(0, queued);
		pop(code_no_error);
		err(4'h5);
		wait4;
		rst = 1;
		tick;
		rst = 0;
		tick;
		pop(code_no_error);
		err(4'ha);
		tick;
		chk(1, trigger_ignore);
		chk(1, msg_load);
		chk(code_trig_ignored, msg_code);
		chk(1, any_error);
		tick;
		chk(0, trigger_ignore);
		chk(0, msg_load);
		pop(code_trig_ignored);
	endtask : t_keep
	initial begin
		repeat (10) tick;
		rst = 0;
		t_codes;
		t_over;
		t_keep;
		end_of_test;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			end_of_test;
		end
	end
endmodule : error_queue_fifo_tb_top
`default_nettype wire

// [dv/host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_model
	import error_queue_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic [3:0] kind,
	input  wire logic       go,
	output var  cmd_facts_type facts
);
	cmd_facts_type f;
	initial facts = '0;
	// Harmless defaults let one field turn each fault on
	always @(posedge mclk) begin
		f = '0;
		f.entry_count = 8'hff;
		f.integer_only = 1'b1;
		f.meas_running = 1'b1;
		f.trig_src_bus = 1'b1;
		f.has_string = 1'b1;
		case (kind)
			4'h1: f.params_needed = 4'h1;
			4'h2: f.exponent_mag = 7'h2c;
			4'h3: f.value_negative = 1'b1;
			4'h4: f.value_fractional = 1'b1;
			4'h5: f.header_suffix = 4'h4;
			4'h6: f.quote_unmatched = 1'b1;
			4'h7: f.string_len = 8'h0d;
			4'h8: f.bracket_unmatched = 1'b1;
			4'h9: f.entry_count = 8'h00;
			4'ha: f.trigger_cmd = 1'b1;
			4'hb: f.init_cmd = 1'b1;
			4'hc: f.read_query = 1'b1;
			4'hd: f.db_modifier = 1'b1;
			4'he: begin
				f.exponent_mag = 7'h2b;
				f.string_len = 8'h0c;
				f.header_suffix = 4'h3;
			end
			default: ;
		endcase
		f.check = go;
		facts <= #1 f;
	end
endmodule : host_model
`default_nettype wire
